// ---- common/tmr_pkg.sv ----
// Purpose: Shared constants for the dual timer/counter block
// Assumes: APB word registers, byte address = 4 * register index
// Notes:   Summary of the behaviour follows
//
// Summary of operation
// - Mode 11 splits unit 0 into two independent 8-bit counters
// - In split mode low carry sets flag 0, high carry sets flag 1
// - Source select 0 counts oscillator divided by 12 (machine cycle)
// - Source select 1 counts pulses on the unit's external count pin
// - Gate bit 0: run bit alone starts and stops counting
// - Gate bit 1: count only while run bit and interrupt pin high
// - Mode register at index 89H, low nibble unit 0, high nibble unit 1
// - Each unit has a run bit in the control register
// - Overflow flag set by carry, cleared when its interrupt is serviced
package tmr_pkg;

    localparam int unsigned ADDR_W = 12;

    // Register indices; byte address is four times the index
    localparam logic [9:0] IDX_CTRL      = 10'h088;
    localparam logic [9:0] IDX_MODE      = 10'h089;
    localparam logic [9:0] IDX_U0_LOW    = 10'h08a;
    localparam logic [9:0] IDX_U1_LOW    = 10'h08b;
    localparam logic [9:0] IDX_U0_HIGH   = 10'h08c;
    localparam logic [9:0] IDX_U1_HIGH   = 10'h08d;

    // Control register fields
    localparam int unsigned CTRL_RUN0    = 4;
    localparam int unsigned CTRL_FLAG0   = 5;
    localparam int unsigned CTRL_RUN1    = 6;
    localparam int unsigned CTRL_FLAG1   = 7;

    // Mode nibble fields, nibble base is 4 * unit
    localparam int unsigned MODE_LSB     = 0;
    localparam int unsigned MODE_SRC     = 2;
    localparam int unsigned MODE_GATE    = 3;
    localparam int unsigned NIBBLE_W     = 4;

    localparam logic [1:0] MODE_PRESCALE = 2'h0;
    localparam logic [1:0] MODE_WIDE     = 2'h1;
    localparam logic [1:0] MODE_RELOAD   = 2'h2;
    localparam logic [1:0] MODE_SPLIT    = 2'h3;

    // Reset values
    localparam logic [7:0] MODE_RST      = 8'h00;
    localparam logic [7:0] CNT_RST       = 8'h00;

    // Machine cycle is twelve oscillator periods
    localparam int unsigned MC_DIV       = 12;
    localparam logic [3:0]  MC_LAST      = 4'(MC_DIV - 1);

endpackage : tmr_pkg

// ---- common/tmr_tick_if.sv ----
// Purpose: Count ticks and gate levels from the pin conditioner
// Assumes: Single clock domain
// Notes:   Index 0 is unit 0, index 1 is unit 1
`timescale 1ns/10ps
`default_nettype none
interface tmr_tick_if;
    logic       mc_tick;
    logic [1:0] ext_tick;
    logic [1:0] gate_lvl;

    modport src (output mc_tick, output ext_tick, output gate_lvl);
    modport dst (input mc_tick, input ext_tick, input gate_lvl);
endinterface : tmr_tick_if
`default_nettype wire

// ---- rtl/tmr_tick_gen.sv ----
// Purpose: Machine-cycle divider and pin synchronisers
// Assumes: Pins are asynchronous to the oscillator clock
// Notes:   External count pulse is a synchronised falling edge
`timescale 1ns/10ps
`default_nettype none
module tmr_tick_gen (
    // Clock and reset
    input  wire logic       clk_i,
    input  wire logic       rst_i,
    // Pins: count pins in [1:0], interrupt pins in [3:2]
    input  wire logic [3:0] pins_i,
    // Ticks to the counters
    tmr_tick_if.src         tick
);

    logic [3:0] div_q, div_d;
    logic [3:0] sync1_q, sync2_q;
    logic [1:0] prev_q;

    ////////////////////////////////////////////////////////////////////////
    always_comb begin
        div_d = (div_q == tmr_pkg::MC_LAST) ? 4'h0 : div_q + 4'h1;
    end

    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            div_q   <= 4'h0;
            sync1_q <= 4'h0;
            sync2_q <= 4'h0;
            prev_q  <= 2'h0;
        end else begin
            div_q   <= div_d;
            sync1_q <= pins_i;
            sync2_q <= sync1_q;
            prev_q  <= sync2_q[1:0];
        end
    end

    ////////////////////////////////////////////////////////////////////////
    assign tick.mc_tick  = (div_q == tmr_pkg::MC_LAST);
    assign tick.ext_tick = prev_q & ~sync2_q[1:0];
    assign tick.gate_lvl = sync2_q[3:2];

    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);

    property p_mc_period;
        tick.mc_tick |=> !tick.mc_tick [*8] ##1 !tick.mc_tick [*3] ##1 tick.mc_tick;
    endproperty
    a_mc_period: assert property (p_mc_period)
        else $error("machine tick period not twelve");

    property p_ext_edge;
        tick.ext_tick[0] |-> $past(sync2_q[0]) && !sync2_q[0];
    endproperty
    a_ext_edge: assert property (p_ext_edge)
        else $error("count tick without pin falling edge");

endmodule : tmr_tick_gen
`default_nettype wire

// ---- rtl/tmr_dual_timer.sv ----
// Purpose: Two timer/counters with mode, run, gate and overflow flags
// Assumes: APB slave, zero wait states, service acks from same clock
// Notes:   Read data is captured in the setup cycle
`timescale 1ns/10ps
`default_nettype none
module tmr_dual_timer (
    // Clock and reset
    input  wire logic                       CLOCK_I,
    input  wire logic                       RST_I,
    // APB slave
    input  wire logic                       PSEL_I,
    input  wire logic                       PENABLE_I,
    input  wire logic                       PWRITE_I,
    input  wire logic [tmr_pkg::ADDR_W-1:0] PADDR_I,
    input  wire logic [31:0]                PWDATA_I,
    output logic      [31:0]                PRDATA_O,
    output logic                            PREADY_O,
    output logic                            PSLVERR_O,
    // Pins
    input  wire logic                       UNIT_A_COUNT_PIN_I,
    input  wire logic                       UNIT_B_COUNT_PIN_I,
    input  wire logic                       EXT_IRQ_A_PIN_I,
    input  wire logic                       EXT_IRQ_B_PIN_I,
    // Interrupt controller side
    input  wire logic                       UNIT0_SERVICED_I,
    input  wire logic                       UNIT1_SERVICED_I,
    output logic                            UNIT0_OVERFLOW_FLAG_O,
    output logic                            UNIT1_OVERFLOW_FLAG_O
);

    tmr_tick_if tick ();

    tmr_tick_gen u_tick (
        .clk_i  (CLOCK_I),
        .rst_i  (RST_I),
        .pins_i ({EXT_IRQ_B_PIN_I, EXT_IRQ_A_PIN_I,
                  UNIT_B_COUNT_PIN_I, UNIT_A_COUNT_PIN_I}),
        .tick   (tick)
    );

    ////////////////////////////////////////////////////////////////////////
    // Bus decode
    logic       access, setup, hit, wr;
    logic [9:0] idx;
    logic [7:0] wbyte;
    logic       wr_ctrl, wr_mode;
    logic [1:0] wr_low, wr_high;
    logic       cnt_wr;

    assign access  = PSEL_I & PENABLE_I;
    assign setup   = PSEL_I & ~PENABLE_I;
    assign idx     = PADDR_I[tmr_pkg::ADDR_W-1:2];
    assign hit     = (PADDR_I[1:0] == 2'h0) &&
                     (idx >= tmr_pkg::IDX_CTRL) && (idx <= tmr_pkg::IDX_U1_HIGH);
    assign wr      = access & PWRITE_I & hit;
    assign wbyte   = PWDATA_I[7:0];
    assign wr_ctrl = wr && (idx == tmr_pkg::IDX_CTRL);
    assign wr_mode = wr && (idx == tmr_pkg::IDX_MODE);
    assign wr_low  = {wr && (idx == tmr_pkg::IDX_U1_LOW),
                      wr && (idx == tmr_pkg::IDX_U0_LOW)};
    assign wr_high = {wr && (idx == tmr_pkg::IDX_U1_HIGH),
                      wr && (idx == tmr_pkg::IDX_U0_HIGH)};
    assign cnt_wr  = |{wr_low, wr_high};

    assign PREADY_O  = 1'b1;
    assign PSLVERR_O = access & ~hit;

    ////////////////////////////////////////////////////////////////////////
    // Configuration and status state
    logic [7:0]  mode_q, mode_d;
    logic [1:0]  run_q, run_d;
    logic [1:0]  flag_q, flag_d;
    logic [31:0] rdata_q, rdata_d;
    logic [7:0]  ctrl_view;

    assign ctrl_view = {flag_q[1], run_q[1], flag_q[0], run_q[0], 4'h0};

    ////////////////////////////////////////////////////////////////////////
    // Counter state
    logic [7:0] low_q  [2];
    logic [7:0] high_q [2];
    logic [7:0] low_d  [2];
    logic [7:0] high_d [2];
    logic [1:0] step, carry;
    logic       split, high_step, high_carry;
    logic [1:0] set_flag;

    always_comb begin
        logic [1:0]  m;
        logic [13:0] s13;
        logic [16:0] s16;
        logic [8:0]  s8;
        m     = 2'h0;
        s13   = 14'h0;
        s16   = 17'h0;
        s8    = 9'h0;
        step  = 2'h0;
        carry = 2'h0;
        split = (mode_q[tmr_pkg::MODE_LSB +: 2] == tmr_pkg::MODE_SPLIT);
        for (int u = 0; u < 2; u++) begin
            m         = mode_q[u*tmr_pkg::NIBBLE_W + tmr_pkg::MODE_LSB +: 2];
            low_d[u]  = low_q[u];
            high_d[u] = high_q[u];
            // Gate off: run bit alone, gate on: run bit and pin
            step[u]   = run_q[u] &
                        (~mode_q[u*tmr_pkg::NIBBLE_W + tmr_pkg::MODE_GATE] |
                         tick.gate_lvl[u]) &
                        (mode_q[u*tmr_pkg::NIBBLE_W + tmr_pkg::MODE_SRC] ?
                         tick.ext_tick[u] : tick.mc_tick);
            if (u == 1 && m == tmr_pkg::MODE_SPLIT) begin
                step[u] = 1'b0;
            end
            if (step[u]) begin
                unique case (m)
                    tmr_pkg::MODE_PRESCALE: begin
                        s13 = {1'b0, high_q[u], low_q[u][4:0]} + 14'h1;
                        {carry[u], high_d[u], low_d[u][4:0]} = s13;
                    end
                    tmr_pkg::MODE_WIDE: begin
                        s16 = {1'b0, high_q[u], low_q[u]} + 17'h1;
                        {carry[u], high_d[u], low_d[u]} = s16;
                    end
                    tmr_pkg::MODE_RELOAD: begin
                        s8 = {1'b0, low_q[u]} + 9'h1;
                        carry[u] = s8[8];
                        low_d[u] = s8[8] ? high_q[u] : s8[7:0];
                    end
                    tmr_pkg::MODE_SPLIT: begin
                        s8 = {1'b0, low_q[u]} + 9'h1;
                        {carry[u], low_d[u]} = s8;
                    end
                endcase
            end
            if (wr_low[u]) begin
                low_d[u] = wbyte;
            end
        end
        // Split high byte borrows unit 1 run bit and the machine cycle
        high_step  = split & run_q[1] & tick.mc_tick;
        high_carry = 1'b0;
        if (high_step) begin
            s8         = {1'b0, high_q[0]} + 9'h1;
            high_carry = s8[8];
            high_d[0]  = s8[7:0];
        end
        for (int u = 0; u < 2; u++) begin
            if (wr_high[u]) begin
                high_d[u] = wbyte;
            end
        end
        set_flag = {carry[1] | high_carry, carry[0]};
    end

    ////////////////////////////////////////////////////////////////////////
    // Registers; a hardware set beats a same-cycle clear
    always_comb begin
        mode_d = wr_mode ? wbyte : mode_q;
        run_d  = wr_ctrl ? {wbyte[tmr_pkg::CTRL_RUN1], wbyte[tmr_pkg::CTRL_RUN0]}
                         : run_q;
        flag_d = set_flag |
                 (wr_ctrl ? {wbyte[tmr_pkg::CTRL_FLAG1], wbyte[tmr_pkg::CTRL_FLAG0]}
                          : flag_q & ~{UNIT1_SERVICED_I, UNIT0_SERVICED_I});
        rdata_d = rdata_q;
        if (setup) begin
            rdata_d = 32'h0;
            unique case (idx)
                tmr_pkg::IDX_CTRL:    rdata_d[7:0] = ctrl_view;
                tmr_pkg::IDX_MODE:    rdata_d[7:0] = mode_q;
                tmr_pkg::IDX_U0_LOW:  rdata_d[7:0] = low_q[0];
                tmr_pkg::IDX_U1_LOW:  rdata_d[7:0] = low_q[1];
                tmr_pkg::IDX_U0_HIGH: rdata_d[7:0] = high_q[0];
                tmr_pkg::IDX_U1_HIGH: rdata_d[7:0] = high_q[1];
                default:              rdata_d      = 32'h0;
            endcase
        end
    end

    always_ff @(posedge CLOCK_I or posedge RST_I) begin
        if (RST_I) begin
            mode_q    <= tmr_pkg::MODE_RST;
            run_q     <= 2'h0;
            flag_q    <= 2'h0;
            rdata_q   <= 32'h0;
            low_q[0]  <= tmr_pkg::CNT_RST;
            low_q[1]  <= tmr_pkg::CNT_RST;
            high_q[0] <= tmr_pkg::CNT_RST;
            high_q[1] <= tmr_pkg::CNT_RST;
        end else begin
            mode_q    <= mode_d;
            run_q     <= run_d;
            flag_q    <= flag_d;
            rdata_q   <= rdata_d;
            low_q[0]  <= low_d[0];
            low_q[1]  <= low_d[1];
            high_q[0] <= high_d[0];
            high_q[1] <= high_d[1];
        end
    end

    assign PRDATA_O              = rdata_q;
    assign UNIT0_OVERFLOW_FLAG_O = flag_q[0];
    assign UNIT1_OVERFLOW_FLAG_O = flag_q[1];

    ////////////////////////////////////////////////////////////////////////
    // Checks
    default clocking cb @(posedge CLOCK_I); endclocking
    default disable iff (RST_I);

    property p_wide_inc;
        step[1] && mode_q[5:4] == tmr_pkg::MODE_WIDE && !cnt_wr
            |=> {high_q[1], low_q[1]} == $past({high_q[1], low_q[1]}) + 16'h1;
    endproperty
    a_wide_inc: assert property (p_wide_inc)
        else $error("16-bit mode did not increment");

    property p_split_low;
        split && step[0] && !cnt_wr |=> low_q[0] == $past(low_q[0]) + 8'h1;
    endproperty
    a_split_low: assert property (p_split_low)
        else $error("split low byte did not count");

    property p_split_flags;
        split && high_step && high_q[0] == 8'hff && !cnt_wr |=> flag_q[1];
    endproperty
    a_split_flags: assert property (p_split_flags)
        else $error("split high carry did not set flag 1");

    property p_u1_hold;
        mode_q[5:4] == tmr_pkg::MODE_SPLIT && !cnt_wr
            |=> $stable(low_q[1]) && $stable(high_q[1]);
    endproperty
    a_u1_hold: assert property (p_u1_hold)
        else $error("unit 1 moved while stopped");

    property p_run_only;
        run_q[0] && !mode_q[3] && !mode_q[2] && tick.mc_tick
            && mode_q[1:0] == tmr_pkg::MODE_WIDE && !cnt_wr
            |=> low_q[0] != $past(low_q[0]);
    endproperty
    a_run_only: assert property (p_run_only)
        else $error("ungated running unit did not count");

    property p_gate_off;
        mode_q[3] && !tick.gate_lvl[0] && !split && !cnt_wr
            |=> $stable(low_q[0]) && $stable(high_q[0]);
    endproperty
    a_gate_off: assert property (p_gate_off)
        else $error("gated unit counted with pin low");

    property p_mode_write;
        wr_mode |=> mode_q == $past(wbyte);
    endproperty
    a_mode_write: assert property (p_mode_write)
        else $error("mode register write lost");

    property p_reload;
        step[1] && mode_q[5:4] == tmr_pkg::MODE_RELOAD && low_q[1] == 8'hff && !cnt_wr
            |=> low_q[1] == $past(high_q[1]) && $stable(high_q[1]) && flag_q[1];
    endproperty
    a_reload: assert property (p_reload)
        else $error("auto reload wrong");

    property p_stopped;
        !run_q[1] && !cnt_wr |=> $stable(low_q[1]) && $stable(high_q[1]);
    endproperty
    a_stopped: assert property (p_stopped)
        else $error("unit 1 counted with run bit clear");

    property p_service;
        UNIT0_SERVICED_I && !set_flag[0] && !wr_ctrl |=> !flag_q[0];
    endproperty
    a_service: assert property (p_service)
        else $error("flag 0 not cleared by service");

    property p_prescale_top;
        step[0] && mode_q[1:0] == tmr_pkg::MODE_PRESCALE && !cnt_wr
            |=> low_q[0][7:5] == $past(low_q[0][7:5]);
    endproperty
    a_prescale_top: assert property (p_prescale_top)
        else $error("prescale mode disturbed low byte top bits");

    property p_carry_flag;
        carry[0] |=> flag_q[0];
    endproperty
    a_carry_flag: assert property (p_carry_flag)
        else $error("carry did not set flag 0");

    property p_gate_off_b;
        mode_q[7] && !tick.gate_lvl[1] && !cnt_wr
            |=> $stable(low_q[1]) && $stable(high_q[1]);
    endproperty
    a_gate_off_b: assert property (p_gate_off_b)
        else $error("gated unit 1 counted with pin low");

    property p_ext_count;
        run_q[0] && mode_q[3:0] == 4'h5 && tick.ext_tick[0] && !cnt_wr
            |=> low_q[0] == $past(low_q[0]) + 8'h1;
    endproperty
    a_ext_count: assert property (p_ext_count)
        else $error("external count pulse not counted");

    property p_stopped_a;
        !run_q[0] && !split && !cnt_wr |=> $stable(low_q[0]) && $stable(high_q[0]);
    endproperty
    a_stopped_a: assert property (p_stopped_a)
        else $error("unit 0 counted with run bit clear");

endmodule : tmr_dual_timer
`default_nettype wire

// ---- verif/tmr_pin_model.sv ----
// Purpose: Far-side model of the count pins and interrupt pins
// Assumes: Driven from the bench through its tasks
// Notes:   Count pins idle high, interrupt pins idle low
`timescale 1ns/10ps
`default_nettype none
module tmr_pin_model (
    // Clock
    input  wire logic clk_i,
    // Pins toward the device
    output logic      cnt_a_o,
    output logic      cnt_b_o,
    output logic      irq_a_o,
    output logic      irq_b_o
);
    initial begin
        cnt_a_o = 1'b1;
        cnt_b_o = 1'b1;
        irq_a_o = 1'b0;
        irq_b_o = 1'b0;
    end

    // Low phase of three clocks, high phase of four between pulses, so the synchroniser sees them
    task automatic pulse(input int unit, input int n);
        for (int i = 0; i < n; i++) begin
            @(posedge clk_i);
            if (unit == 0) cnt_a_o <= 1'b0;
            else cnt_b_o <= 1'b0;
            repeat (3) @(posedge clk_i);
            if (unit == 0) cnt_a_o <= 1'b1;
            else cnt_b_o <= 1'b1;
            repeat (3) @(posedge clk_i);
        end
    endtask : pulse

    task automatic gate(input int unit, input logic lvl);
        @(posedge clk_i);
        if (unit == 0) irq_a_o <= lvl;
        else irq_b_o <= lvl;
        repeat (4) @(posedge clk_i);
    endtask : gate
endmodule : tmr_pin_model
`default_nettype wire

// ---- verif/tb_tmr_dual_timer.sv ----
// Purpose: Self-checking bench for the dual timer/counter
// Assumes: Zero-wait APB slave, flags cleared by a CTRL write of zero
// Notes:   Read windows are short so the next machine tick cannot land
`timescale 1ns/10ps
`default_nettype none
`define CHK(a, b) begin n_compared++; if ((a) !== (b)) begin miscompares++; \
    $display("Error at %0t: got %h expected %h", $time, (a), (b)); end end
module tb_tmr_dual_timer;
    logic        clk;
    logic        rst;
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [11:0] paddr;
    logic [31:0] pwdata;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    logic        cnt_a;
    logic        cnt_b;
    logic        irq_a;
    logic        irq_b;
    logic        srv0;
    logic        srv1;
    logic        flag0;
    logic        flag1;
    int          miscompares;
    int          n_compared;
    int          cycles;
    logic [31:0] r;
    logic        e;

    localparam logic [11:0] A_CTRL = {tmr_pkg::IDX_CTRL, 2'h0};
    localparam logic [11:0] A_MODE = {tmr_pkg::IDX_MODE, 2'h0};
    localparam logic [11:0] A_U0L  = {tmr_pkg::IDX_U0_LOW, 2'h0};
    localparam logic [11:0] A_U1L  = {tmr_pkg::IDX_U1_LOW, 2'h0};
    localparam logic [11:0] A_U0H  = {tmr_pkg::IDX_U0_HIGH, 2'h0};
    localparam logic [11:0] A_U1H  = {tmr_pkg::IDX_U1_HIGH, 2'h0};

    tmr_dual_timer tmr_dual_timer_i (
        .CLOCK_I(clk), .RST_I(rst), .PSEL_I(psel), .PENABLE_I(penable),
        .PWRITE_I(pwrite), .PADDR_I(paddr), .PWDATA_I(pwdata), .PRDATA_O(prdata),
        .PREADY_O(pready), .PSLVERR_O(pslverr), .UNIT_A_COUNT_PIN_I(cnt_a),
        .UNIT_B_COUNT_PIN_I(cnt_b), .EXT_IRQ_A_PIN_I(irq_a), .EXT_IRQ_B_PIN_I(irq_b),
        .UNIT0_SERVICED_I(srv0), .UNIT1_SERVICED_I(srv1),
        .UNIT0_OVERFLOW_FLAG_O(flag0), .UNIT1_OVERFLOW_FLAG_O(flag1));

    tmr_pin_model pin_model_i (
        .clk_i(clk), .cnt_a_o(cnt_a), .cnt_b_o(cnt_b), .irq_a_o(irq_a), .irq_b_o(irq_b));

    always #2.5 clk = ~clk;

    task automatic print_verdict;
        $display("Comparisons %0d, mismatches %0d", n_compared, miscompares);
        if (miscompares == 0 && n_compared > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask : print_verdict

    // Hang guard: the whole run needs under a thousand cycles
    always @(posedge clk) begin
        cycles++;
        if (cycles == 20000) begin
            miscompares++;
            $display("Error at %0t: timeout", $time);
            print_verdict();
        end
    end

    task automatic apb(input logic wr, input logic [11:0] a, input logic [7:0] d);
        @(posedge clk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= wr;
        paddr   <= a;
        pwdata  <= {24'h0, d};
        @(posedge clk);
        penable <= 1'b1;
        @(posedge clk);
        while (pready !== 1'b1) @(posedge clk);
        r = prdata;
        e = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    task automatic rdchk(input logic [11:0] a, input logic [7:0] x);
        apb(1'b0, a, 8'h00);
        `CHK(r, {24'h0, x})
    endtask : rdchk

    task automatic wait_flag(input int u);
        for (int i = 0; i < 60 && (u ? flag1 : flag0) !== 1'b1; i++) @(posedge clk);
    endtask : wait_flag

    task automatic t_map;
        rdchk(A_MODE, 8'h00);
        rdchk(A_CTRL, 8'h00);
        `CHK(pready, 1'b1)
        apb(1'b1, A_MODE, 8'ha5);
        rdchk(A_MODE, 8'ha5);
        apb(1'b1, A_MODE, 8'h00);
        apb(1'b0, 12'h238, 8'h00);
        `CHK({e, r}, 33'h100000000)
        apb(1'b0, A_CTRL + 12'h001, 8'h00);
        `CHK(e, 1'b1)
    endtask : t_map

    task automatic t_rate;
        apb(1'b1, A_MODE, 8'h01);
        apb(1'b1, A_U0L, 8'h00);
        apb(1'b1, A_CTRL, 8'h10);
        repeat (120) @(posedge clk);
        apb(1'b1, A_CTRL, 8'h00);
        apb(1'b0, A_U0L, 8'h00);
        `CHK(r >= 32'd9 && r <= 32'd11, 1'b1)
    endtask : t_rate

    task automatic t_overflow(input int u, input logic [7:0] md, input logic [7:0] hi,
                              input logic [7:0] lo_x, input logic [7:0] hi_x);
        apb(1'b1, A_MODE, (u != 0) ? {md[3:0], 4'h0} : md);
        apb(1'b1, (u != 0) ? A_U1H : A_U0H, hi);
        apb(1'b1, (u != 0) ? A_U1L : A_U0L, 8'hff);
        apb(1'b1, A_CTRL, (u != 0) ? 8'h40 : 8'h10);
        wait_flag(u);
        `CHK((u != 0) ? flag1 : flag0, 1'b1)
        rdchk((u != 0) ? A_U1L : A_U0L, lo_x);
        rdchk((u != 0) ? A_U1H : A_U0H, hi_x);
        @(posedge clk);
        if (u != 0) begin
            srv1 <= 1'b1;
        end else begin
            srv0 <= 1'b1;
        end
        @(posedge clk);
        srv0 <= 1'b0;
        srv1 <= 1'b0;
        @(posedge clk);
        `CHK((u != 0) ? flag1 : flag0, 1'b0)
        apb(1'b1, A_CTRL, 8'h00);
    endtask : t_overflow

    task automatic t_split;
        apb(1'b1, A_MODE, 8'h33);
        apb(1'b1, A_U0L, 8'hff);
        apb(1'b1, A_U0H, 8'hff);
        apb(1'b1, A_U1L, 8'h55);
        apb(1'b1, A_CTRL, 8'h50);
        wait_flag(0);
        `CHK({flag0, flag1}, 2'h3)
        repeat (30) @(posedge clk);
        rdchk(A_U1L, 8'h55);
        apb(1'b1, A_CTRL, 8'h00);
        apb(1'b1, A_U0L, 8'h11);
        apb(1'b1, A_U0H, 8'h00);
        apb(1'b1, A_CTRL, 8'h40);
        repeat (60) @(posedge clk);
        apb(1'b1, A_CTRL, 8'h00);
        rdchk(A_U0L, 8'h11);
        apb(1'b0, A_U0H, 8'h00);
        `CHK(r >= 32'd4 && r <= 32'd6, 1'b1)
    endtask : t_split

    task automatic t_ext;
        apb(1'b1, A_MODE, 8'h55);
        apb(1'b1, A_U0L, 8'h00);
        apb(1'b1, A_U1L, 8'h00);
        apb(1'b1, A_CTRL, 8'h50);
        pin_model_i.pulse(0, 5);
        pin_model_i.pulse(1, 3);
        repeat (6) @(posedge clk);
        rdchk(A_U0L, 8'h05);
        rdchk(A_U1L, 8'h03);
        apb(1'b1, A_CTRL, 8'h00);
    endtask : t_ext

    task automatic t_gate(input int u);
        logic [11:0] al;
        al = (u != 0) ? A_U1L : A_U0L;
        apb(1'b1, A_MODE, (u != 0) ? 8'hd0 : 8'h0d);
        apb(1'b1, al, 8'h00);
        apb(1'b1, A_CTRL, (u != 0) ? 8'h40 : 8'h10);
        pin_model_i.pulse(u, 3);
        repeat (6) @(posedge clk);
        rdchk(al, 8'h00);
        pin_model_i.gate(u, 1'b1);
        pin_model_i.pulse(u, 3);
        repeat (6) @(posedge clk);
        rdchk(al, 8'h03);
        apb(1'b1, A_CTRL, 8'h00);
        pin_model_i.pulse(u, 2);
        repeat (6) @(posedge clk);
        rdchk(al, 8'h03);
        pin_model_i.gate(u, 1'b0);
    endtask : t_gate

    initial begin
        clk = 1'b0;
        rst = 1'b1;
        {psel, penable, pwrite, srv0, srv1} = 5'h00;
        paddr = 12'h000;
        pwdata = 32'h00000000;
        repeat (10) @(posedge clk);
        rst <= 1'b0;
        t_map();
        t_rate();
        t_overflow(0, 8'h01, 8'hff, 8'h00, 8'h00);
        t_overflow(0, 8'h00, 8'hff, 8'he0, 8'h00);
        t_overflow(0, 8'h02, 8'hf0, 8'hf0, 8'hf0);
        t_overflow(1, 8'h01, 8'hff, 8'h00, 8'h00);
        t_overflow(1, 8'h00, 8'hff, 8'he0, 8'h00);
        t_overflow(1, 8'h02, 8'hf0, 8'hf0, 8'hf0);
        t_split();
        t_ext();
        t_gate(0);
        t_gate(1);
        print_verdict();
    end
endmodule : tb_tmr_dual_timer
`default_nettype wire
